//--- hw/rml_ref_monitor.sv
// Reference monitor, lock detector and normal/free-run mode controller.
// Assumes tdmClk is the synthesized loop clock at twice the TDM rate; sys_clk from crystal.
`timescale 1ns/1ps
module rml_ref_monitor import rml_pkg::*; #(
  parameter int CW = 16,
  parameter int PERIOD_CYC = REF_PERIOD_CYC,
  parameter int FB_DIVIDE = FB_DIV
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic tdmClk,
  // Pins in
  input wire logic refIn,
  input wire logic xtal_in,
  // Status and control out
  output logic lockFlag,
  output logic refFail,
  output logic loopSelRef,
  output logic freeRunMode,
  // Clock pins and drive enable out
  output logic tdm_clock_out,
  output logic xtal_buffered_clock_out,
  output logic xtal_drive_out,
  output logic outDriveEn
);

  ////////////////////////////////////////////////////////////////////////////
  // Derived thresholds
  localparam int TOL_RAW = PERIOD_CYC * FREQ_TOL_PPM / PPM_SCALE;
  localparam int TOL_I = (TOL_RAW < 1) ? 1 : TOL_RAW;
  localparam logic [CW-1:0] NOM = CW'(PERIOD_CYC);
  localparam logic [CW-1:0] TOL = CW'(TOL_I);
  localparam logic [CW-1:0] HALF = CW'(PERIOD_CYC / 2);
  localparam logic [CW-1:0] MISS_AT = CW'(PERIOD_CYC + PERIOD_CYC / 2);
  localparam logic [CW-1:0] LOSS_TH = CW'(PERIOD_CYC * LOSS_DDEG / FULL_DDEG);
  localparam logic [CW-1:0] GOOD_TH = CW'(PERIOD_CYC * GOOD_DDEG / FULL_DDEG);
  localparam logic [CW-1:0] JUMP_TH = CW'(PERIOD_CYC * JUMP_DDEG / FULL_DDEG);
  localparam logic [CW-1:0] AGE_MAX = {CW{1'b1}};
  localparam logic [CW-1:0] FB_LAST = CW'(FB_DIVIDE - 1);
  localparam logic [2:0] MISS_LIM = 3'(MISS_LIMIT_EDGES);
  localparam logic [3:0] RELOCK_N = 4'(RELOCK_CLOCKS);
  localparam logic [3:0] RECOVER_N = 4'(RECOVER_EDGES);

  // Distance between two counts
  function automatic logic [CW-1:0] absDiff(input logic [CW-1:0] a, input logic [CW-1:0] b);
    absDiff = (a > b) ? a - b : b - a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: synthesized clock, feedback divider and TDM output
  logic [CW-1:0] fbCnt;
  logic fbToggle;

  // Output toggles on every rising loop clock edge; it follows crystal or reference as the loop does
  always_ff @(posedge tdmClk or negedge arst_n) begin
    if (!arst_n) begin
      tdm_clock_out <= 1'b0;
    end else begin
      tdm_clock_out <= ~tdm_clock_out;
    end
  end

  // Feedback divider back down to the reference rate; event leaves as a toggle
  always_ff @(posedge tdmClk or negedge arst_n) begin
    if (!arst_n) begin
      fbCnt <= '0;
      fbToggle <= 1'b0;
    end else if (fbCnt == FB_LAST) begin
      fbCnt <= '0;
      fbToggle <= ~fbToggle;
    end else begin
      fbCnt <= fbCnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: three flops, change taken once second and third agree
  logic [2:0] refSync;
  logic [2:0] fbSync;
  logic [2:0] xtalSync;
  logic refLevel;
  logic fbLevel;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refSync <= '0;
      fbSync <= '0;
      xtalSync <= '0;
    end else begin
      refSync <= {refSync[1:0], refIn};
      fbSync <= {fbSync[1:0], fbToggle};
      xtalSync <= {xtalSync[1:0], xtal_in};
    end
  end

  // Filtered levels; only the second and third stages are looked at
  logic refRise;
  logic fbEvent;
  assign refRise = (refSync[2] == refSync[1]) && refSync[1] && !refLevel;
  assign fbEvent = (fbSync[2] == fbSync[1]) && (fbSync[1] != fbLevel);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refLevel <= 1'b0;
      fbLevel <= 1'b0;
    end else begin
      if (refSync[2] == refSync[1]) begin
        refLevel <= refSync[1];
      end
      if (fbSync[2] == fbSync[1]) begin
        fbLevel <= fbSync[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal buffer and drive: 25 MHz sampled at 125 MHz, so edges carry jitter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      xtal_buffered_clock_out <= 1'b0;
      xtal_drive_out <= 1'b0;
    end else if (xtalSync[2] == xtalSync[1]) begin
      xtal_buffered_clock_out <= xtalSync[1];
      xtal_drive_out <= ~xtalSync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period timer and missing-edge count
  logic [CW-1:0] refAge;
  logic [2:0] missCnt;
  logic primed;
  logic missBad;

  assign missBad = (missCnt > MISS_LIM);

  // A missed edge rearms the timer half a period on, so the next slot is one period later
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refAge <= '0;
      missCnt <= '0;
      primed <= 1'b0;
    end else if (refRise) begin
      refAge <= '0;
      missCnt <= '0;
      primed <= 1'b1;
    end else if (primed && (refAge == MISS_AT)) begin
      refAge <= HALF;
      if (!missBad) begin
        missCnt <= missCnt + 1'b1;
      end
    end else if (refAge != AGE_MAX) begin
      refAge <= refAge + 1'b1;
    end
  end

  // Time since last feedback edge
  logic [CW-1:0] fbAge;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fbAge <= AGE_MAX;
    end else if (fbEvent) begin
      fbAge <= '0;
    end else if (fbAge != AGE_MAX) begin
      fbAge <= fbAge + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-edge judgement of frequency and phase
  logic [CW-1:0] period;
  logic [CW-1:0] phaseErr;
  logic [CW-1:0] lastErr;
  logic haveErr;
  logic freqBad;
  logic jumpBad;
  rml_mode_t mode;

  assign period = refAge + 1'b1;
  assign freqBad = (missCnt != '0) || (absDiff(period, NOM) > TOL);
  assign phaseErr = (fbAge == AGE_MAX) ? HALF :
                    (fbAge > NOM) ? HALF :
                    (fbAge > HALF) ? NOM - fbAge : fbAge;
  assign jumpBad = haveErr && (mode == RML_NORMAL) && (absDiff(phaseErr, lastErr) > JUMP_TH);

  // Previous phase error, kept to spot a step
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastErr <= '0;
      haveErr <= 1'b0;
    end else if (refRise && primed) begin
      lastErr <= phaseErr;
      haveErr <= (fbAge != AGE_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failure flag and recovery count
  logic failSet;
  logic [3:0] goodPeriods;
  logic refValid;

  assign failSet = missBad || (refRise && primed && (freqBad || jumpBad));
  assign refValid = (goodPeriods == RECOVER_N);

  // Setting wins over clearing in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      goodPeriods <= '0;
    end else if (failSet) begin
      goodPeriods <= '0;
    end else if (refRise && primed && !refValid) begin
      goodPeriods <= goodPeriods + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refFail <= 1'b0;
    end else if (failSet) begin
      refFail <= 1'b1;
    end else if (refValid) begin
      refFail <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode controller
  rml_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    case (mode)
      RML_FREERUN: begin
        if (refValid && !refFail && !failSet) begin
          next_mode = RML_NORMAL;
        end
      end
      RML_NORMAL: begin
        if (failSet || refFail) begin
          next_mode = RML_FREERUN;
        end
      end
      default: begin
        next_mode = RML_FREERUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= RML_FREERUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Loop input select to the analog loop: 1 reference, 0 crystal
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      loopSelRef <= 1'b0;
      freeRunMode <= 1'b1;
    end else begin
      loopSelRef <= (next_mode == RML_NORMAL);
      freeRunMode <= (next_mode == RML_FREERUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock detector with hysteresis
  logic [3:0] closeCnt;
  logic lockOk;

  assign lockOk = (mode == RML_NORMAL) && !refFail && !failSet;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      closeCnt <= '0;
    end else if (!lockOk) begin
      closeCnt <= '0;
    end else if (refRise) begin
      if (phaseErr > LOSS_TH) begin
        closeCnt <= '0;
      end else if (phaseErr <= GOOD_TH) begin
        if (closeCnt != RELOCK_N) begin
          closeCnt <= closeCnt + 1'b1;
        end
      end else if (!lockFlag) begin
        closeCnt <= '0;
      end
    end
  end

  // Lock only while locked in normal mode with no failure
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lockFlag <= 1'b0;
    end else if (!lockOk) begin
      lockFlag <= 1'b0;
    end else if (refRise && (phaseErr > LOSS_TH)) begin
      lockFlag <= 1'b0;
    end else if (closeCnt == RELOCK_N) begin
      lockFlag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers released in reset; enable rises on the first edge after release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      outDriveEn <= 1'b0;
    end else begin
      outDriveEn <= 1'b1;
    end
  end

endmodule // rml_ref_monitor

//--- inc/rml_pkg.sv
// Constants for the reference monitor and lock/mode controller.
// Assumes a 125 MHz crystal-derived system clock and a nominal 8 kHz reference.
//
// Behaviour
// - Lock flag high only while locked to a valid reference.
// - Phase error above 90 degrees drops the lock flag.
// - Relock needs eight consecutive reference clocks within 22.5 degrees.
// - Fail flag rises on frequency deviation beyond 130 ppm.
// - Fail flag rises when more than three consecutive edges are missing.
// - Fail flag rises on an abrupt phase shift of the reference.
// - Any failure switches the loop input to the crystal: free-run.
// - Good reference and low fail flag switch the loop back to reference.
// - Mode controller starts in free-run after power-up.
// - Valid reference moves free-run to normal without outside command.
// - Reset returns the mode controller to free-run.
// - During reset every output is released to high impedance; the code only drives outDriveEn low.
// - Free-run output clock follows only the crystal.
// - Normal-mode output clock is synchronised to the reference.
// - One synthesized 65.536 MHz clock output for TDM use.
// - A 25 MHz buffered copy of the crystal is driven out.
// - Failure checks run continuously, on every reference period; the phase-step check runs in normal mode only.
package rml_pkg;

  // Clock and reference timing
  localparam int SYS_CLK_PERIOD_NS = 8;
  localparam int REF_PERIOD_NS = 125000;
  localparam int REF_PERIOD_CYC = REF_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int FREQ_TOL_PPM = 130;
  localparam int PPM_SCALE = 1000000;

  // Phase limits in tenths of a degree
  localparam int FULL_DDEG = 3600;
  localparam int LOSS_DDEG = 900;
  localparam int GOOD_DDEG = 225;
  localparam int JUMP_DDEG = 450;

  // Edge and period counts
  localparam int RELOCK_CLOCKS = 8;
  localparam int MISS_LIMIT_EDGES = 3;
  localparam int RECOVER_EDGES = 8;
  localparam int FB_DIV = 16384;

  // Mode states, gray along free-run <-> normal
  typedef enum logic [1:0] {
    RML_FREERUN = 2'h0,
    RML_NORMAL = 2'h1
  } rml_mode_t;

endpackage

//--- verification/rml_ref_monitor_properties.sv
// Checker for the reference monitor: reset, mode, lock and fail relations.
// Assumes both clock domains share the asynchronous arst_n.
`timescale 1ns/1ps
module rml_ref_monitor_checker import rml_pkg::*; #(
  parameter int CW = 16,
  parameter int PERIOD_CYC = REF_PERIOD_CYC,
  parameter int FB_DIVIDE = FB_DIV
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic tdmClk,
  // Pins in
  input wire logic refIn,
  input wire logic xtal_in,
  // Status and clock pins out
  input wire logic lockFlag,
  input wire logic refFail,
  input wire logic loopSelRef,
  input wire logic freeRunMode,
  input wire logic tdm_clock_out,
  input wire logic xtal_buffered_clock_out,
  input wire logic xtal_drive_out,
  input wire logic outDriveEn
);
  // Slack of 16 covers the input synchronizer
  localparam int MISS_AT = 4 * PERIOD_CYC + PERIOD_CYC / 2 + 16;
  localparam int HOLD_MIN = 7 * (PERIOD_CYC - 1);
  logic refQ;
  logic refSeen;
  int quietCnt;
  int runCnt;
  int failCnt;
  ////////////////////////////////////////////////////////////////////////////
  // Run lengths: quiet time after the first edge, normal mode, failure
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refQ <= 1'b0;
      refSeen <= 1'b0;
      quietCnt <= 0;
      runCnt <= 0;
      failCnt <= 0;
    end else begin
      refQ <= refIn;
      refSeen <= refSeen | (refIn & ~refQ);
      quietCnt <= (refIn & ~refQ) ? 0 : quietCnt + int'(refSeen);
      runCnt <= loopSelRef ? runCnt + 1 : 0;
      failCnt <= refFail ? failCnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Free-run state as seen at the pins
  sequence s_freerun;
    freeRunMode && !loopSelRef && !lockFlag;
  endsequence
  a_reset_hiz: assert property (@(posedge sys_clk) !arst_n |->
    !outDriveEn && !refFail && freeRunMode && !lockFlag) else $error("outputs not released in reset");
  a_drive_after_rst: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(arst_n) |-> outDriveEn) else $error("outputs not driven after reset");
  a_fail_to_freerun: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(refFail) |-> ##[0:2] s_freerun) else $error("failure did not force free-run");
  a_sel_mode_pair: assert property (@(posedge sys_clk) disable iff (!arst_n)
    loopSelRef != freeRunMode) else $error("loop select disagrees with mode");
  a_lock_needs_ref: assert property (@(posedge sys_clk) disable iff (!arst_n)
    lockFlag |-> loopSelRef) else $error("lock shown outside normal mode");
  a_back_after_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(loopSelRef) |-> !refFail && !$past(refFail)) else $error("normal mode while failed");
  a_relock_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(lockFlag) |-> runCnt >= HOLD_MIN) else $error("lock raised too early");
  a_fail_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(refFail) |-> failCnt >= HOLD_MIN) else $error("fail flag cleared too early");
  a_miss_fails: assert property (@(posedge sys_clk) disable iff (!arst_n)
    quietCnt == MISS_AT |-> refFail) else $error("missing edges not flagged");
  a_tdm_toggle: assert property (@(posedge tdmClk) disable iff (!arst_n)
    $past(arst_n) |-> tdm_clock_out != $past(tdm_clock_out)) else $error("tdm clock stalled");
  a_xtal_pair: assert property (@(posedge sys_clk) disable iff (!arst_n)
    outDriveEn |-> xtal_drive_out != xtal_buffered_clock_out) else $error("crystal pins not inverse");
endmodule // rml_ref_monitor_checker

bind rml_ref_monitor rml_ref_monitor_checker #(.CW(CW), .PERIOD_CYC(PERIOD_CYC), .FB_DIVIDE(FB_DIVIDE))
  i_rml_ref_monitor_checker (.sys_clk(sys_clk), .arst_n(arst_n), .tdmClk(tdmClk), .refIn(refIn),
  .xtal_in(xtal_in), .lockFlag(lockFlag), .refFail(refFail), .loopSelRef(loopSelRef),
  .freeRunMode(freeRunMode), .tdm_clock_out(tdm_clock_out), .xtal_buffered_clock_out(xtal_buffered_clock_out),
  .xtal_drive_out(xtal_drive_out), .outDriveEn(outDriveEn));

//--- verification/rml_ref_source.sv
// Model of the external reference source, paced by the loop clock.
// Assumes halfLen 25 with a 64 ns tdmClk gives the shortened nominal period.
`timescale 1ns/1ps
module rml_ref_source (
  // Clock and reset
  input wire logic tdmClk,
  input wire logic arst_n,
  // Bench controls
  input wire logic run,
  input wire logic hold,
  input wire logic [7:0] halfLen,
  // Reference pin
  output logic refIn
);
  logic [8:0] cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Square wave; pin pulled low while stopped, hold freezes the phase
  always @(posedge tdmClk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 9'h000;
      refIn <= 1'b0;
    end else if (!hold) begin
      cnt <= (cnt >= {halfLen, 1'b0} - 9'h001) ? 9'h000 : cnt + 9'h001;
      refIn <= run && (cnt < {1'b0, halfLen});
    end
  end
endmodule // rml_ref_source

//--- verification/rml_ref_monitor_tb_top.sv
// Testbench: reset, acquire, drift, missing edges, phase step, mid-run reset.
// Assumes a period shortened to 400 cycles and a loop divider of 50 to match.
`timescale 1ns/1ps
module rml_ref_monitor_tb_top;
  localparam int PER = 400;
  logic sys_clk = 1'b0;
  logic tdmClk = 1'b0;
  // Starts high so that the first assertion is a real falling edge for every async reset
  logic arst_n = 1'b1;
  logic xtal_in = 1'b0;
  logic run = 1'b0;
  logic hold = 1'b0;
  logic [7:0] halfLen = 8'h19;
  logic refIn, lockFlag, refFail, loopSelRef, freeRunMode, outDriveEn;
  logic xtalBuf;
  int err_total = 0;
  int n_compared = 0;
  rml_ref_monitor #(.PERIOD_CYC(PER), .FB_DIVIDE(50)) i_rml_ref_monitor (.sys_clk(sys_clk), .arst_n(arst_n),
    .tdmClk(tdmClk), .refIn(refIn), .xtal_in(xtal_in), .lockFlag(lockFlag), .refFail(refFail),
    .loopSelRef(loopSelRef), .freeRunMode(freeRunMode), .tdm_clock_out(), .xtal_buffered_clock_out(xtalBuf),
    .xtal_drive_out(), .outDriveEn(outDriveEn));
  rml_ref_source i_rml_ref_source (.tdmClk(tdmClk), .arst_n(arst_n), .run(run), .hold(hold),
    .halfLen(halfLen), .refIn(refIn));
  ////////////////////////////////////////////////////////////////////////////
  // Clocks; loop clock offset so its edges never meet sys_clk edges
  always #4 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #32 tdmClk = ~tdmClk;
  end
  // Crystal stand-in, two cycles a level; a level held one cycle never passes the agreeing synchroniser
  always begin
    repeat (2) @(negedge sys_clk);
    xtal_in <= ~xtal_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: flag mismatch, seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic t_reset();
    cyc(3);
    check(outDriveEn, 1'b0);
    check(freeRunMode, 1'b1);
    check(lockFlag, 1'b0);
    check(refFail, 1'b0);
  endtask
  task automatic t_release();
    cyc(2);
    check(outDriveEn, 1'b1);
    check(freeRunMode, 1'b1);
    check(loopSelRef, 1'b0);
  endtask
  task automatic expect_freerun();
    cyc(3);
    check(freeRunMode, 1'b1);
    check(loopSelRef, 1'b0);
    check(lockFlag, 1'b0);
  endtask
  // Bounds are generous: 8 good periods plus priming, then 8 in phase
  task automatic recover();
    int i;
    logic xtalPrev;
    for (i = 0; i < 16 * PER && loopSelRef !== 1'b1; i++) @(negedge sys_clk);
    check(refFail, 1'b0);
    check(freeRunMode, 1'b0);
    check(lockFlag, 1'b0);
    for (i = 0; i < 12 * PER && lockFlag !== 1'b1; i++) @(negedge sys_clk);
    check(lockFlag, 1'b1);
    check(loopSelRef, 1'b1);
    // Buffered crystal copy must keep moving with the stand-in, one level per two cycles
    xtalPrev = xtalBuf;
    cyc(2);
    check(xtalBuf, ~xtalPrev);
  endtask
  // Long then short periods, so the phase comes back where it was
  task automatic t_drift();
    @(posedge refIn);
    halfLen = 8'h1A;
    repeat (2) @(posedge refIn);
    halfLen = 8'h18;
    repeat (2) @(posedge refIn);
    halfLen = 8'h19;
    @(negedge sys_clk);
    check(refFail, 1'b1);
    expect_freerun();
    recover();
  endtask
  task automatic t_missing();
    @(posedge refIn);
    @(negedge sys_clk);
    run <= 1'b0;
    cyc(3 * PER + PER / 8);
    check(refFail, 1'b0);
    cyc(3 * PER / 2);
    check(refFail, 1'b1);
    expect_freerun();
    run <= 1'b1;
    recover();
  endtask
  // Two steps adding up to one period restore the alignment
  task automatic t_phase();
    int i;
    @(posedge tdmClk);
    hold <= 1'b1;
    repeat (12) @(posedge tdmClk);
    hold <= 1'b0;
    for (i = 0; i < 3 * PER && refFail !== 1'b1; i++) @(negedge sys_clk);
    check(refFail, 1'b1);
    expect_freerun();
    @(posedge tdmClk);
    hold <= 1'b1;
    repeat (38) @(posedge tdmClk);
    hold <= 1'b0;
    recover();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset held 5 cycles at start
  initial begin
    arst_n <= 1'b0;
    t_reset();
    cyc(2);
    arst_n <= 1'b1;
    t_release();
    run <= 1'b1;
    recover();
    t_drift();
    t_missing();
    t_phase();
    arst_n <= 1'b0;
    t_reset();
    // Held past one loop clock edge so the link domain sees the reset too
    cyc(6);
    arst_n <= 1'b1;
    t_release();
    give_verdict();
  end
  // Watchdog, nearly three times the expected run
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end
endmodule // rml_ref_monitor_tb_top
